// >>> logic/bus_area_select_and_read_wait_control.sv
// APB register pair for area select and read wait control, plus the
// state counter that times one external bus cycle from those settings.
// Assumes presetn is the power-on reset; manual reset never reaches here.
`timescale 1ns/100ps

module bus_area_select_and_read_wait_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bus_cfg_pkg::cyc_req_t req,
    input wire logic [1:0] long_wait_a02,
    input wire logic [1:0] long_wait_a6,
    input wire logic [1:0] refresh_wait,
    input wire logic wait_n,
    output bus_cfg_pkg::bus_mode_t mode,
    output logic cyc_busy,
    output logic cyc_done,
    output bus_cfg_pkg::strobe_pins_t strobes
);
    import bus_cfg_pkg::*;

    typedef struct packed {
        logic [15:0] abc;
        logic [15:0] rwc;
        logic [31:0] rdata;
        logic ready;
        logic err;
        cyc_state_t st;
        logic [2:0] cnt;
        logic sample;
        logic busy;
        logic done;
        logic wait_s1;
        logic wait_s2;
        strobe_pins_t pins;
        bus_mode_t mode;
    } state_t;

    state_t s_reg;
    state_t s_next;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic hit_abc;
        logic hit_rwc;
        logic area_en;
        logic [2:0] len;
        logic smp;
        hit_abc = (paddr == area_bus_ctrl_off);
        hit_rwc = (paddr == read_wait_ctrl_off);
        area_en = s_reg.rwc[area_wait_lsb + 32'(req.area)];
        len = one_state;
        smp = 1'b0;
        s_next = s_reg;
        s_next.done = 1'b0;

        // One wait state keeps every bus output registered
        if (psel && penable && !s_reg.ready) begin
            s_next.ready = 1'b1;
            s_next.err = !(hit_abc || hit_rwc);
            s_next.rdata = 32'h0000_0000;
            if (hit_abc) begin
                s_next.rdata[15:0] = s_reg.abc & area_bus_wmask;
            end else if (hit_rwc) begin
                s_next.rdata[15:0] = s_reg.rwc | read_wait_ones;
            end
        end else if (s_reg.ready) begin
            s_next.ready = 1'b0;
            s_next.err = 1'b0;
            if (psel && penable && pwrite && hit_abc) begin
                s_next.abc = pwdata[15:0] & area_bus_wmask;
            end
            if (psel && penable && pwrite && hit_rwc) begin
                s_next.rwc = pwdata[15:0] | read_wait_ones;
            end
        end

        s_next.mode.dram_space_enable = s_reg.abc[dram_en_bit];
        s_next.mode.mux_io_enable = s_reg.abc[mux_io_bit];
        s_next.mode.parallel_access_mode = s_reg.abc[parallel_bit];
        s_next.mode.read_strobe_duty = s_reg.abc[rd_duty_bit];
        s_next.mode.byte_strobe_select = s_reg.abc[byte_sel_bit];

        // Wait pin crosses in from outside
        s_next.wait_s1 = !wait_n;
        s_next.wait_s2 = s_reg.wait_s1;

        // Length of the fixed part and whether the wait pin counts
        if (req.refresh) begin
            if (s_reg.rwc[area_wait_lsb + 1]) begin
                len = long_pitch_states + {1'b0, refresh_wait};
            end
        end else if (req.on_chip && (req.area == 3'h0 || req.area == 3'h7)) begin
            len = one_state;
        end else if (req.on_chip && req.area == 3'h5) begin
            len = periph_states;
        end else if (req.area == 3'h6 && s_reg.abc[mux_io_bit]) begin
            len = mux_io_states;
            smp = 1'b1;
        end else if (req.is_write) begin
            if (req.area == 3'h1 && s_reg.rwc[dram_pitch_bit]) begin
                len = long_pitch_states;
                smp = 1'b1;
            end
        end else if (req.area == 3'h0 || req.area == 3'h2) begin
            len = one_state + {1'b0, long_wait_a02} + 3'h1;
            smp = area_en;
        end else if (req.area == 3'h6) begin
            len = one_state + {1'b0, long_wait_a6} + 3'h1;
            smp = area_en;
        end else if (area_en) begin
            len = long_pitch_states;
            smp = 1'b1;
        end

        unique case (s_reg.st)
            st_idle: begin
                if (req.start) begin
                    s_next.st = st_base;
                    s_next.cnt = len;
                    s_next.sample = smp;
                    s_next.busy = 1'b1;
                    if (s_reg.abc[byte_sel_bit]) begin
                        s_next.pins.pin_lo_wr = req.is_write & (req.write_hi | req.write_lo);
                        s_next.pins.pin_a0_hi = req.write_hi;
                        s_next.pins.pin_hi_lo = req.write_lo;
                    end else begin
                        s_next.pins.pin_lo_wr = req.is_write & req.write_lo;
                        s_next.pins.pin_a0_hi = req.addr0;
                        s_next.pins.pin_hi_lo = req.is_write & req.write_hi;
                    end
                end
            end
            st_base: begin
                s_next.cnt = s_reg.cnt - 3'h1;
                if (s_reg.cnt == 3'h1) begin
                    // Low wait in the last state stretches the cycle
                    if (s_reg.sample && s_reg.wait_s2) begin
                        s_next.st = st_wait;
                    end else begin
                        s_next.st = st_idle;
                        s_next.busy = 1'b0;
                        s_next.done = 1'b1;
                        s_next.pins = '0;
                    end
                end
            end
            st_wait: begin
                if (!s_reg.wait_s2) begin
                    s_next.st = st_idle;
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                    s_next.pins = '0;
                end
            end
            default: begin
                s_next.st = st_idle;
                s_next.busy = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Only power-on reset loads setting defaults; after that only APB writes change them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.abc <= area_bus_ctrl_rst;
            s_reg.rwc <= read_wait_ctrl_rst;
            s_reg.st <= st_idle;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.rdata;
    assign pready = s_reg.ready;
    assign pslverr = s_reg.err;
    assign mode = s_reg.mode;
    assign cyc_busy = s_reg.busy;
    assign cyc_done = s_reg.done;
    assign strobes = s_reg.pins;

endmodule

// >>> logic/bus_cfg_pkg.sv
// Constants and carriers for the area select and read wait block.
// Assumes a 32-bit APB master and a bus sequencer that issues cycle requests.
package bus_cfg_pkg;

    localparam logic [11:0] area_bus_ctrl_off = 12'h000;
    localparam logic [11:0] read_wait_ctrl_off = 12'h004;

    localparam logic [15:0] area_bus_ctrl_rst = 16'h0000;
    localparam logic [15:0] read_wait_ctrl_rst = 16'hffff;
    localparam logic [15:0] area_bus_wmask = 16'hf800;
    localparam logic [15:0] read_wait_wmask = 16'hff02;
    localparam logic [15:0] read_wait_ones = 16'h00fd;

    localparam int dram_en_bit = 15;
    localparam int mux_io_bit = 14;
    localparam int parallel_bit = 13;
    localparam int rd_duty_bit = 12;
    localparam int byte_sel_bit = 11;
    localparam int area_wait_lsb = 8;
    localparam int dram_pitch_bit = 1;

    localparam logic [2:0] one_state = 3'h1;
    localparam logic [2:0] long_pitch_states = 3'h2;
    localparam logic [2:0] periph_states = 3'h3;
    localparam logic [2:0] mux_io_states = 3'h4;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_base = 2'b01,
        st_wait = 2'b10
    } cyc_state_t;

    typedef struct packed {
        logic start;
        logic [2:0] area;
        logic is_write;
        logic on_chip;
        logic refresh;
        logic write_hi;
        logic write_lo;
        logic addr0;
    } cyc_req_t;

    typedef struct packed {
        logic pin_lo_wr;
        logic pin_a0_hi;
        logic pin_hi_lo;
    } strobe_pins_t;

    typedef struct packed {
        logic dram_space_enable;
        logic mux_io_enable;
        logic parallel_access_mode;
        logic read_strobe_duty;
        logic byte_strobe_select;
    } bus_mode_t;

endpackage

// >>> sim/bus_area_select_and_read_wait_control_bench.sv
// Bench for the area select and read wait block: registers and cycle lengths.
// Assumes long waits 3 and 2 states and refresh wait 3, tied below.
`timescale 1ns/100ps
module bus_area_select_and_read_wait_control_bench;
    import bus_cfg_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, wait_n, cyc_busy, cyc_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] stall;
    cyc_req_t req;
    bus_mode_t mode;
    strobe_pins_t strobes;
    int fail_count = 0, n_checks = 0, cycles = 0, n;
    // Row: area/bus, read wait, area, {write, on-chip, refresh}, stall, states
    logic [47:0] rows [15] = '{48'h0000ffff3002, 48'h0000ffff0004, 48'h0000ffff6003,
        48'h0000ffff0251, 48'h0000ffff7251, 48'h0000ffff5253, 48'h0000ffff1155,
        48'h0000ffff1402, 48'h000000ff3051, 48'h000000ff1151, 48'h4000ffff6004,
        48'h3800ffff4401, 48'h8000ffff1002, 48'h800000fd1401, 48'h800000fd1001};
    bus_area_select_and_read_wait_control bus_area_select_and_read_wait_control_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .req, .long_wait_a02(2'h2),
        .long_wait_a6(2'h1), .refresh_wait(2'h3), .wait_n, .mode, .cyc_busy, .cyc_done, .strobes);
    ext_wait_source ext_wait_source_i (.pclk, .presetn, .start(req.start), .stall, .wait_n);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Read data and error taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic cyc(input logic [2:0] a, input logic [2:0] f, input logic [3:0] s);
        @(posedge pclk);
        req <= '{1'b1, a, f[2], f[1], f[0], 1'b1, 1'b0, 1'b0};
        stall <= s;
        @(posedge pclk);
        req.start <= 1'b0;
        n = 0;
        #1;
        while (cyc_done !== 1'b1) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask
    task automatic rst_vals;
        apb(1'b0, area_bus_ctrl_off, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, read_wait_ctrl_off, 32'h0);
        chk(r, 32'hffff);
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, stall} = '0;
        req = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rst_vals();
        // Area/bus written first so pitch is cleared only with DRAM on
        foreach (rows[i]) begin
            apb(1'b1, area_bus_ctrl_off, {16'h0, rows[i][47:32]});
            apb(1'b1, read_wait_ctrl_off, {16'h0, rows[i][31:16]});
            cyc(rows[i][14:12], rows[i][10:8], rows[i][7:4]);
            chk(n, {28'h0, rows[i][3:0]});
        end
        apb(1'b1, area_bus_ctrl_off, 32'hffff);
        apb(1'b0, area_bus_ctrl_off, 32'h0);
        chk(r, 32'hf800);
        apb(1'b1, read_wait_ctrl_off, 32'h0);
        apb(1'b0, read_wait_ctrl_off, 32'h0);
        chk(r, 32'h00fd);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, err}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rst_vals();
        cyc(3'h3, 3'h0, 4'h6);
        // Two fixed states, then the wait pin held low for six more plus sync lag
        chk(n, 32'h9);
        end_of_test();
    end
endmodule

// >>> sim/bus_cfg_monitor.sv
// Checker for the area select and read wait block.
// Assumes binding to the block top; one clock, async low reset.
`timescale 1ns/100ps
module bus_cfg_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire bus_cfg_pkg::cyc_req_t req,
    input wire bus_cfg_pkg::bus_mode_t mode,
    input wire logic cyc_busy,
    input wire logic cyc_done,
    input wire bus_cfg_pkg::strobe_pins_t strobes
);
    import bus_cfg_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    sequence s_take; req.start && !cyc_busy; endsequence
    sequence s_rd; s_take ##0 !req.is_write && !req.refresh; endsequence
    property p_mode; pready && pwrite && !pslverr && paddr == area_bus_ctrl_off
        |-> ##2 mode == $past(pwdata[15:11], 2); endproperty
    a_mode: assert property (p_mode) else $error("mode copy wrong");
    property p_rsv; pready && !pwrite && paddr == area_bus_ctrl_off |-> prdata[10:0] == 11'h000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_rom; s_rd ##0 req.on_chip && req.area inside {3'h0, 3'h7} |-> ##1 cyc_busy ##1 cyc_done; endproperty
    a_rom: assert property (p_rom) else $error("on-chip memory read length");
    property p_per; s_rd ##0 req.on_chip && req.area == 3'h5 |=> cyc_busy [*3] ##1 cyc_done; endproperty
    a_per: assert property (p_per) else $error("peripheral read length");
    property p_mux; s_rd ##0 !req.on_chip && mode.mux_io_enable && req.area == 3'h6 |=> cyc_busy [*4]; endproperty
    a_mux: assert property (p_mux) else $error("mux read too short");
    property p_ref; s_take ##0 req.refresh |-> ##[2:6] cyc_done; endproperty
    a_ref: assert property (p_ref) else $error("refresh length");
    property p_alt; s_take ##0 req.is_write && mode.byte_strobe_select |=>
        strobes.pin_a0_hi == $past(req.write_hi) && strobes.pin_hi_lo == $past(req.write_lo); endproperty
    a_alt: assert property (p_alt) else $error("alternate strobe pins");
    property p_std; s_take ##0 req.is_write && !mode.byte_strobe_select |=>
        strobes.pin_lo_wr == $past(req.write_lo) && strobes.pin_a0_hi == $past(req.addr0); endproperty
    a_std: assert property (p_std) else $error("standard strobe pins");
endmodule
bind bus_area_select_and_read_wait_control bus_cfg_monitor bus_cfg_monitor_i (.pclk, .presetn, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .req, .mode, .cyc_busy, .cyc_done, .strobes);

// >>> sim/ext_wait_source.sv
// Model of a slow external device: holds the wait pin low for a set time.
// Assumes the bench sets stall before each cycle start.
`timescale 1ns/100ps
module ext_wait_source (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [3:0] stall,
    output logic wait_n
);
    logic [3:0] left_reg;
    // Pulled-up line, so a released pin reads high
    assign wait_n = !((start && stall != 4'h0) || left_reg != 4'h0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            left_reg <= 4'h0;
        else
            left_reg <= start ? stall : left_reg - {3'h0, left_reg != 4'h0};
    end
endmodule
